// ### verilog/bcp_pkg.sv
// Constants and helpers shared by the burst channel peripheral controller
package bcp_pkg;
    // ****************************************************************
    // APB register map of the controller
    // ****************************************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_ADDR = 8'h04;
    localparam logic [7:0] OFS_COUNT = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_BUF = 8'h40;
    localparam logic [7:0] OFS_BUF_END = 8'h7C;
    localparam logic [7:0] OFS_MAP_SLOT_HIGH_WORD = 8'h00;

    // CTRL fields
    localparam int CTRL_START = 0;
    localparam int CTRL_INBOUND = 1;
    localparam int CTRL_PAR_EN = 2;
    localparam int CTRL_MAP_EN = 3;
    localparam int CTRL_MAP_LOAD = 4;
    localparam int CTRL_CLEAR = 5;
    // STATUS fields
    localparam int STAT_BUSY = 0;
    localparam int STAT_PAR_ERR = 1;
    localparam int STAT_PROT_ERR = 2;
    localparam int STAT_OUT_PAR_ERR = 3;
    localparam int STAT_REFUSED = 4;
    localparam int STAT_IDX_LO = 8;
    // ADDR fields
    localparam int ADDR_W = 21;
    localparam int ADDR_FIRST_REG_SEL = 20;
    localparam int SLOT_W = 10;
    localparam int PAGE_DENY_BIT = 0;

    // ****************************************************************
    // Sizes and reset values
    // ****************************************************************
    localparam int WORD_W = 16;
    localparam int BUF_DEPTH = 16;
    localparam int CNT_W = 5;
    localparam int SYNC_W = 22;
    localparam int BREAK_PULSES_DEF = 4;
    localparam logic [20:0] ADDR_RST = 21'h000000;
    localparam logic [4:0] COUNT_RST = 5'h00;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ADDR = 3'h1,
        ST_XFER = 3'h3,
        ST_TAIL = 3'h2,
        ST_BREAK = 3'h6
    } bcp_state_t;

    // Parity bit that makes data plus parity hold an odd count of ones
    function automatic logic oddPar(input logic [15:0] w);
        oddPar = ~(^w);
    endfunction
endpackage

// ### verilog/bcp_sync.sv
// Two-flop synchroniser for the channel pins
`timescale 1ns/100ps
module bcp_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } bcp_sync_t;

    bcp_sync_t regs_q;
    bcp_sync_t regs_d;

    always_comb begin
        regs_d.meta = asyncIn;
        regs_d.stable = regs_q.meta;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            regs_q <= '0;
        end else begin
            regs_q <= regs_d;
        end
    end

    assign syncOut = regs_q.stable;
endmodule // bcp_sync

// ### verilog/bcp_ctrl.sv
// Peripheral controller that drives a burst channel and reports to software over APB
// How it works
// - Finish whole burst on parity fault, act on it afterwards.
// - Stay selected one cycle after last inbound.
// - Ignore fault lines during address cycle.
// - Outbound parity error recorded, burst completes.
// - After protection fault, stop sending/expecting words.
// - Inbound: watch protection fault one extra cycle.
// - Outbound: no monitoring after burst ends.
// - Wait counted sync pulses between requests.
// - Map load sets special and inbound flags.
// - Map load address: slot number, bit 20.
// - Map load word count and start even.
// - Odd parity over sixteen bits plus parity.
// - One word per sync clock falling edge.
//
// Local design decision: the APB slave port.
`timescale 1ns/100ps
module bcp_ctrl #(
    parameter int BREAK_PULSES = bcp_pkg::BREAK_PULSES_DEF
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic syncClk,
    input wire logic busReady,
    input wire logic wordStrobe,
    input wire logic parityFault,
    input wire logic protFault,
    input wire logic [15:0] channelDataLinesIn,
    output logic [15:0] channelDataLinesOut,
    output logic channelDataLinesOe,
    input wire logic dataParityLineIn,
    output logic dataParityLineOut,
    output logic dataParityLineOe,
    output logic requestOut,
    output logic selectOut,
    output logic ctlWordValid,
    output logic [20:0] addrWord,
    output logic parityEnableFlag,
    output logic mapEnableFlag,
    output logic specialFunctionFlag,
    output logic inboundDirectionFlag
);
    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        bcp_pkg::bcp_state_t st;
        logic busy;
        logic req;
        logic sel;
        logic ctlV;
        logic drv;
        logic inb;
        logic parEn;
        logic mapEn;
        logic mapLd;
        logic [20:0] addr;
        logic [4:0] cnt;
        logic [4:0] idx;
        logic [7:0] brk;
        logic parErr;
        logic protErr;
        logic outParErr;
        logic refused;
        logic clkPrev;
        logic [15:0] dOut;
        logic pOut;
        logic [15:0][15:0] wordBuf;
        logic [31:0] rdata;
        logic slverr;
    } bcp_regs_t;

    bcp_regs_t regs_q;
    bcp_regs_t regs_d;

    logic [21:0] pinsSync;
    logic sClk;
    logic sReady;
    logic sStrobe;
    logic sParFault;
    logic sProtFault;
    logic [15:0] sData;
    logic sPar;
    logic fallEdge;
    logic apbSetup;
    logic apbWr;
    logic addrHit;
    logic lastWord;
    logic [3:0] bufIdx;

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    bcp_sync #(
        .WIDTH(bcp_pkg::SYNC_W)
    ) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .asyncIn({syncClk, busReady, wordStrobe, parityFault, protFault,
            channelDataLinesIn, dataParityLineIn}),
        .syncOut(pinsSync)
    );

    assign {sClk, sReady, sStrobe, sParFault, sProtFault, sData, sPar} = pinsSync;
    // Bus words are sampled on the falling sync edge; all pins share one latency
    assign fallEdge = regs_q.clkPrev & ~sClk;
    assign apbSetup = psel & ~penable;
    assign apbWr = psel & penable & pwrite;
    assign addrHit = (paddr == bcp_pkg::OFS_CTRL) || (paddr == bcp_pkg::OFS_ADDR)
        || (paddr == bcp_pkg::OFS_COUNT) || (paddr == bcp_pkg::OFS_STATUS)
        || ((paddr >= bcp_pkg::OFS_BUF) && (paddr <= bcp_pkg::OFS_BUF_END)
        && (paddr[1:0] == 2'h0));
    assign lastWord = ((regs_q.idx + 5'h01) == regs_q.cnt);
    assign bufIdx = paddr[5:2];

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        regs_d = regs_q;
        regs_d.clkPrev = sClk;

        // Register access: read data is registered in the setup cycle
        if (apbSetup) begin
            regs_d.slverr = ~addrHit;
            regs_d.rdata = 32'h00000000;
            case (paddr)
                bcp_pkg::OFS_CTRL: begin
                    regs_d.rdata[bcp_pkg::CTRL_INBOUND] = regs_q.inb;
                    regs_d.rdata[bcp_pkg::CTRL_PAR_EN] = regs_q.parEn;
                    regs_d.rdata[bcp_pkg::CTRL_MAP_EN] = regs_q.mapEn;
                    regs_d.rdata[bcp_pkg::CTRL_MAP_LOAD] = regs_q.mapLd;
                end
                bcp_pkg::OFS_ADDR: regs_d.rdata[20:0] = regs_q.addr;
                bcp_pkg::OFS_COUNT: regs_d.rdata[4:0] = regs_q.cnt;
                bcp_pkg::OFS_STATUS: begin
                    regs_d.rdata[bcp_pkg::STAT_BUSY] = regs_q.busy;
                    regs_d.rdata[bcp_pkg::STAT_PAR_ERR] = regs_q.parErr;
                    regs_d.rdata[bcp_pkg::STAT_PROT_ERR] = regs_q.protErr;
                    regs_d.rdata[bcp_pkg::STAT_OUT_PAR_ERR] = regs_q.outParErr;
                    regs_d.rdata[bcp_pkg::STAT_REFUSED] = regs_q.refused;
                    regs_d.rdata[12:8] = regs_q.idx;
                end
                default: begin
                    if (addrHit) begin
                        regs_d.rdata[15:0] = regs_q.wordBuf[bufIdx];
                    end
                end
            endcase
        end

        // Setup is frozen while a burst runs; only clear and the buffer stay open
        if (apbWr) begin
            case (paddr)
                bcp_pkg::OFS_CTRL: begin
                    if (pwdata[bcp_pkg::CTRL_CLEAR]) begin
                        regs_d.parErr = 1'b0;
                        regs_d.protErr = 1'b0;
                        regs_d.outParErr = 1'b0;
                        regs_d.refused = 1'b0;
                    end
                    if (!regs_q.busy) begin
                        regs_d.parEn = pwdata[bcp_pkg::CTRL_PAR_EN];
                        regs_d.mapEn = pwdata[bcp_pkg::CTRL_MAP_EN];
                        regs_d.mapLd = pwdata[bcp_pkg::CTRL_MAP_LOAD];
                        // A map load is always an inbound transfer
                        regs_d.inb = pwdata[bcp_pkg::CTRL_INBOUND]
                            | pwdata[bcp_pkg::CTRL_MAP_LOAD];
                        if (pwdata[bcp_pkg::CTRL_START]) begin
                            if ((regs_q.cnt == 5'h00) || (regs_q.cnt > 5'h10)
                                || (pwdata[bcp_pkg::CTRL_MAP_LOAD]
                                && (regs_q.cnt[0]
                                || regs_q.addr[bcp_pkg::ADDR_FIRST_REG_SEL]))) begin
                                regs_d.refused = 1'b1;
                            end else begin
                                regs_d.busy = 1'b1;
                                regs_d.req = 1'b1;
                            end
                        end
                    end
                end
                bcp_pkg::OFS_ADDR: begin
                    if (!regs_q.busy) begin
                        regs_d.addr = pwdata[20:0];
                    end
                end
                bcp_pkg::OFS_COUNT: begin
                    if (!regs_q.busy) begin
                        regs_d.cnt = pwdata[4:0];
                    end
                end
                default: begin
                    if (addrHit && (paddr != bcp_pkg::OFS_STATUS)) begin
                        regs_d.wordBuf[bufIdx] = pwdata[15:0];
                    end
                end
            endcase
        end

        // Link sequencing, one step per falling sync edge; flag sets win over clear
        if (fallEdge) begin
            case (regs_q.st)
                bcp_pkg::ST_IDLE: begin
                    if (regs_q.req && sReady) begin
                        regs_d.st = bcp_pkg::ST_ADDR;
                        regs_d.req = 1'b0;
                        regs_d.sel = 1'b1;
                        regs_d.ctlV = 1'b1;
                        regs_d.idx = 5'h00;
                    end
                end
                bcp_pkg::ST_ADDR: begin
                    // Fault lines may still carry the previous burst here
                    regs_d.st = bcp_pkg::ST_XFER;
                    regs_d.ctlV = 1'b0;
                    if (regs_q.inb) begin
                        regs_d.drv = 1'b1;
                        regs_d.dOut = regs_q.wordBuf[0];
                        regs_d.pOut = bcp_pkg::oddPar(regs_q.wordBuf[0]);
                    end
                end
                bcp_pkg::ST_XFER: begin
                    if (sProtFault) begin
                        regs_d.protErr = 1'b1;
                        regs_d.drv = 1'b0;
                        regs_d.sel = 1'b0;
                        regs_d.brk = 8'h00;
                        regs_d.st = bcp_pkg::ST_BREAK;
                    end else begin
                        if (regs_q.inb && sParFault) begin
                            regs_d.parErr = 1'b1;
                        end
                        if (sStrobe && regs_q.inb) begin
                            if (lastWord) begin
                                regs_d.drv = 1'b0;
                                regs_d.st = bcp_pkg::ST_TAIL;
                            end else begin
                                regs_d.idx = regs_q.idx + 5'h01;
                                regs_d.dOut = regs_q.wordBuf[regs_q.idx[3:0] + 4'h1];
                                regs_d.pOut = bcp_pkg::oddPar(
                                    regs_q.wordBuf[regs_q.idx[3:0] + 4'h1]);
                            end
                        end else if (sStrobe) begin
                            regs_d.wordBuf[regs_q.idx[3:0]] = sData;
                            if (regs_q.parEn && !(^{sData, sPar})) begin
                                regs_d.outParErr = 1'b1;
                            end
                            if (lastWord) begin
                                regs_d.sel = 1'b0;
                                regs_d.brk = 8'h00;
                                regs_d.st = bcp_pkg::ST_BREAK;
                            end else begin
                                regs_d.idx = regs_q.idx + 5'h01;
                            end
                        end
                    end
                end
                bcp_pkg::ST_TAIL: begin
                    if (sParFault) begin
                        regs_d.parErr = 1'b1;
                    end
                    if (sProtFault) begin
                        regs_d.protErr = 1'b1;
                    end
                    regs_d.sel = 1'b0;
                    regs_d.brk = 8'h00;
                    regs_d.st = bcp_pkg::ST_BREAK;
                end
                bcp_pkg::ST_BREAK: begin
                    // Gives lower-priority controllers a turn at the channel
                    if (regs_q.brk == 8'(BREAK_PULSES - 1)) begin
                        regs_d.st = bcp_pkg::ST_IDLE;
                        regs_d.busy = 1'b0;
                    end else begin
                        regs_d.brk = regs_q.brk + 8'h01;
                    end
                end
                default: begin
                    regs_d.st = bcp_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            regs_q <= '0;
            regs_q.st <= bcp_pkg::ST_IDLE;
            regs_q.addr <= bcp_pkg::ADDR_RST;
            regs_q.cnt <= bcp_pkg::COUNT_RST;
        end else begin
            regs_q <= regs_d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign pready = psel & penable;
    assign prdata = regs_q.rdata;
    assign pslverr = psel & penable & regs_q.slverr;
    assign channelDataLinesOut = regs_q.dOut;
    assign channelDataLinesOe = regs_q.drv;
    assign dataParityLineOut = regs_q.pOut;
    assign dataParityLineOe = regs_q.drv;
    assign requestOut = regs_q.req;
    assign selectOut = regs_q.sel;
    assign ctlWordValid = regs_q.ctlV;
    assign addrWord = regs_q.addr;
    assign parityEnableFlag = regs_q.parEn;
    assign mapEnableFlag = regs_q.mapEn;
    assign specialFunctionFlag = regs_q.mapLd;
    assign inboundDirectionFlag = regs_q.inb;

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_odd_parity_out: assert property (@(posedge clk) disable iff (sys_rst)
        channelDataLinesOe |-> (^{channelDataLinesOut, dataParityLineOut}))
        else $error("driven word lacks odd parity");
    a_tail_select: assert property (@(posedge clk) disable iff (sys_rst)
        (regs_q.st == bcp_pkg::ST_XFER && fallEdge && regs_q.inb && sStrobe
        && lastWord && !sProtFault) |=> (selectOut && !channelDataLinesOe))
        else $error("select dropped before tail cycle");
    a_tail_once: assert property (@(posedge clk) disable iff (sys_rst)
        (regs_q.st == bcp_pkg::ST_TAIL && fallEdge)
        |=> (regs_q.st == bcp_pkg::ST_BREAK && !selectOut))
        else $error("tail cycle not followed by break");
    a_prot_abort: assert property (@(posedge clk) disable iff (sys_rst)
        (regs_q.st == bcp_pkg::ST_XFER && fallEdge && sProtFault)
        |=> (!channelDataLinesOe && regs_q.protErr && !selectOut))
        else $error("protection fault did not abort");
    a_par_sticky: assert property (@(posedge clk) disable iff (sys_rst)
        (regs_q.st == bcp_pkg::ST_XFER && fallEdge && regs_q.inb && sParFault
        && !sProtFault) |=> regs_q.parErr [*2])
        else $error("parity fault not held");
    a_addr_ignore: assert property (@(posedge clk) disable iff (sys_rst)
        (regs_q.st == bcp_pkg::ST_ADDR && fallEdge && !apbWr)
        |=> ($stable(regs_q.parErr) && $stable(regs_q.protErr)))
        else $error("fault taken during address cycle");
    a_break_quiet: assert property (@(posedge clk) disable iff (sys_rst)
        (regs_q.st == bcp_pkg::ST_BREAK) |-> (!requestOut && !selectOut))
        else $error("request during break");
    a_map_flags: assert property (@(posedge clk) disable iff (sys_rst)
        (ctlWordValid && specialFunctionFlag) |-> (inboundDirectionFlag && !regs_q.cnt[0]))
        else $error("map load with bad flags or count");
    a_out_nodrive: assert property (@(posedge clk) disable iff (sys_rst)
        (selectOut && !inboundDirectionFlag) |-> !channelDataLinesOe)
        else $error("driving lines on outbound transfer");
endmodule // bcp_ctrl

// ### bench/bcp_bus_model.sv
// Behavioural model of the burst channel bus controller with its page map
`timescale 1ns/100ps
module bcp_bus_model (
    output logic syncClk,
    output logic busReady,
    output logic wordStrobe,
    output logic parityFault,
    output logic protFault,
    output logic [15:0] channelDataLinesIn,
    output logic dataParityLineIn,
    input wire logic [15:0] channelDataLinesOut,
    input wire logic channelDataLinesOe,
    input wire logic dataParityLineOut,
    input wire logic dataParityLineOe,
    input wire logic requestOut,
    input wire logic selectOut,
    input wire logic ctlWordValid,
    input wire logic [20:0] addrWord,
    input wire logic parityEnableFlag,
    input wire logic mapEnableFlag,
    input wire logic specialFunctionFlag,
    input wire logic inboundDirectionFlag,
    input wire logic [4:0] wordCount,
    input wire logic [4:0] pfAt,
    input wire logic badOutPar,
    input wire logic strayFault
);
    // ****************************************
    // Map, captured control word and transfer state
    // ****************************************
    logic [15:0] mapReg [0:2047];
    logic [15:0] rx [0:31];
    logic [15:0] mData, nData;
    logic [20:0] base;
    logic mPar, nPar, inb, parEn, mapEn, ld, act, tail, selLate;
    logic nRdy, nStb, nPf, nProt;
    int k;

    // Released lines toggle so stale data never passes
    assign channelDataLinesIn = channelDataLinesOe ? channelDataLinesOut : mData;
    assign dataParityLineIn = dataParityLineOe ? dataParityLineOut : mPar;

    function automatic logic den(input int i);
        logic [19:0] la;
        la = base[19:0] + 20'(i);
        return mapEn && !ld && mapReg[{la[19:10], 1'b0}][0];
    endfunction

    task automatic offer(input int i);
        if (den(i)) begin
            nProt = 1'b1;
            act = 1'b0;
            nStb = 1'b0;
            nRdy = 1'b1;
        end else begin
            nData = 16'h3C00 ^ 16'(i);
            nPar = ~(^nData) ^ (badOutPar && i == 1);
            nStb = 1'b1;
        end
    endtask

    initial begin
        syncClk = 1'b1;
        forever #16 syncClk = ~syncClk;
    end

    initial begin
        for (int i = 0; i < 2048; i++) mapReg[i] = 16'h0000;
        busReady = 1'b1;
        {wordStrobe, parityFault, protFault, mPar, act, tail, selLate} = '0;
        mData = 16'h0000;
        k = 0;
    end

    // Sample on the falling edge, drive at mid cycle to keep hold margin
    always begin
        @(negedge syncClk);
        nRdy = busReady;
        nStb = wordStrobe;
        nPf = strayFault && requestOut && busReady && !act;
        nProt = 1'b0;
        nData = ~mData;
        nPar = ~mPar;
        if (tail) selLate = selectOut;
        tail = 1'b0;
        if (ctlWordValid && !act) begin
            inb = inboundDirectionFlag;
            parEn = parityEnableFlag;
            mapEn = mapEnableFlag;
            ld = specialFunctionFlag && inboundDirectionFlag;
            base = addrWord;
            k = 0;
            act = 1'b1;
            nRdy = 1'b0;
            if (inb) nStb = 1'b1;
            else offer(0);
        end else if (act && wordStrobe) begin
            if (inb) begin
                rx[k] = channelDataLinesIn;
                if (parEn && !(^{channelDataLinesIn, dataParityLineIn})) nPf = 1'b1;
                if (k >= int'(pfAt)) nPf = 1'b1;
                if (ld) mapReg[{base[9:0], base[20]} + 11'(k)] = channelDataLinesIn;
                if (den(k)) nProt = 1'b1;
            end
            k++;
            if (nProt || k == int'(wordCount)) begin
                act = 1'b0;
                nStb = 1'b0;
                nRdy = 1'b1;
                tail = inb;
            end else if (!inb) offer(k);
        end
        @(posedge syncClk);
        busReady = nRdy;
        wordStrobe = nStb;
        parityFault = nPf;
        protFault = nProt;
        mData = nData;
        mPar = nPar;
    end
endmodule // bcp_bus_model

// ### bench/tb.sv
// Self-checking bench for the burst channel peripheral controller
`timescale 1ns/100ps
module tb;
    // ****************************************
    // Signals, instances and helpers
    // ****************************************
    localparam logic [31:0] GO = 32'h1 << bcp_pkg::CTRL_START,
        INB = 32'h1 << bcp_pkg::CTRL_INBOUND,
        PEN = 32'h1 << bcp_pkg::CTRL_PAR_EN,
        MEN = 32'h1 << bcp_pkg::CTRL_MAP_EN,
        LD = 32'h1 << bcp_pkg::CTRL_MAP_LOAD,
        CLR = 32'h1 << bcp_pkg::CTRL_CLEAR;
    logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic syncClk, busReady, wordStrobe, parityFault, protFault;
    logic [15:0] channelDataLinesIn, channelDataLinesOut;
    logic channelDataLinesOe, dataParityLineIn, dataParityLineOut, dataParityLineOe;
    logic requestOut, selectOut, ctlWordValid;
    logic [20:0] addrWord;
    logic parityEnableFlag, mapEnableFlag, specialFunctionFlag, inboundDirectionFlag;
    logic [4:0] wordCount, pfAt;
    logic badOutPar, strayFault;
    int mismatches, nChecks;

    bcp_ctrl #(.BREAK_PULSES(2)) i_dut (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .syncClk, .busReady, .wordStrobe, .parityFault,
        .protFault, .channelDataLinesIn, .channelDataLinesOut, .channelDataLinesOe,
        .dataParityLineIn, .dataParityLineOut, .dataParityLineOe, .requestOut, .selectOut,
        .ctlWordValid, .addrWord, .parityEnableFlag, .mapEnableFlag, .specialFunctionFlag,
        .inboundDirectionFlag);
    bcp_bus_model i_bus (.syncClk, .busReady, .wordStrobe, .parityFault, .protFault,
        .channelDataLinesIn, .dataParityLineIn, .channelDataLinesOut, .channelDataLinesOe,
        .dataParityLineOut, .dataParityLineOe, .requestOut, .selectOut, .ctlWordValid,
        .addrWord, .parityEnableFlag, .mapEnableFlag, .specialFunctionFlag,
        .inboundDirectionFlag, .wordCount, .pfAt, .badOutPar, .strayFault);

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        nChecks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic burst(input logic [31:0] ctl, input logic [20:0] adr, input logic [4:0] n);
        apb(1'b1, bcp_pkg::OFS_ADDR, 32'(adr));
        apb(1'b1, bcp_pkg::OFS_COUNT, 32'(n));
        wordCount <= n;
        apb(1'b1, bcp_pkg::OFS_CTRL, ctl);
        rd = 32'h1;
        while (rd[0] !== 1'b0) apb(1'b0, bcp_pkg::OFS_STATUS, 32'h0);
    endtask

    task automatic clr();
        apb(1'b1, bcp_pkg::OFS_CTRL, CLR);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_regs();
        apb(1'b0, bcp_pkg::OFS_ADDR, 32'h0);
        chk("addr reset", rd, 32'(bcp_pkg::ADDR_RST));
        apb(1'b0, bcp_pkg::OFS_COUNT, 32'h0);
        chk("count reset", rd, 32'(bcp_pkg::COUNT_RST));
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped err", 32'(err), 32'h1);
        $display("test registers done");
    endtask

    task automatic t_inbound();
        for (int i = 0; i < 4; i++) apb(1'b1, bcp_pkg::OFS_BUF + 8'(4 * i), 32'h0000A500 + i);
        burst(GO | INB | PEN, 21'h00400, 5'h04);
        for (int i = 0; i < 4; i++) chk("rx word", 32'(i_bus.rx[i]), 32'h0000A500 + i);
        chk("in status", rd & 32'h1E, 32'h0);
        chk("par flag", 32'(i_bus.parEn), 32'h1);
        chk("late select", 32'(i_bus.selLate), 32'h1);
        pfAt <= 5'h02;
        burst(GO | INB | PEN, 21'h00400, 5'h04);
        pfAt <= 5'h1F;
        chk("late parity", rd & 32'h1E, 32'h2);
        chk("whole burst", 32'(i_bus.k), 32'h4);
        clr();
        apb(1'b0, bcp_pkg::OFS_STATUS, 32'h0);
        chk("cleared", rd & 32'h1E, 32'h0);
        strayFault <= 1'b1;
        burst(GO | INB | PEN, 21'h00000, 5'h02);
        strayFault <= 1'b0;
        chk("stray fault", rd & 32'h1E, 32'h0);
        $display("test inbound done");
    endtask

    task automatic t_outbound();
        for (int b = 0; b < 2; b++) begin
            badOutPar <= b[0];
            burst(GO | PEN, 21'h00800, 5'h03);
            chk("out status", rd & 32'h1E, b[0] ? 32'h8 : 32'h0);
            for (int i = 0; i < 3; i++) begin
                apb(1'b0, bcp_pkg::OFS_BUF + 8'(4 * i), 32'h0);
                chk("out word", rd & 32'hFFFF, 32'h00003C00 ^ i);
            end
            clr();
        end
        badOutPar <= 1'b0;
        $display("test outbound done");
    endtask

    task automatic t_map();
        apb(1'b1, bcp_pkg::OFS_BUF, 32'h00000001);
        apb(1'b1, bcp_pkg::OFS_BUF + 8'h04, 32'h00001234);
        burst(GO | LD | INB, 21'h00005, 5'h02);
        chk("slot high", 32'(i_bus.mapReg[10]), 32'h1);
        chk("slot low", 32'(i_bus.mapReg[11]), 32'h1234);
        burst(GO | INB | MEN, 21'h01400, 5'h03);
        chk("prot in", rd & 32'h1E, 32'h4);
        chk("stop in", 32'(i_bus.k), 32'h1);
        chk("ready back", 32'(busReady), 32'h1);
        clr();
        burst(GO | INB | MEN, 21'h013FE, 5'h03);
        chk("prot last", rd & 32'h1E, 32'h4);
        clr();
        burst(GO | MEN, 21'h01400, 5'h03);
        chk("prot out", rd & 32'h1E, 32'h4);
        chk("stop out", 32'(i_bus.k), 32'h0);
        clr();
        burst(GO | INB, 21'h01400, 5'h03);
        chk("map off", rd & 32'h1E, 32'h0);
        burst(GO | LD | INB, 21'h00005, 5'h01);
        chk("odd load", rd & 32'h10, 32'h10);
        $display("test map done");
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", nChecks, mismatches);
        if (mismatches == 0 && nChecks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (80000) @(posedge clk);
        mismatches++;
        end_sim();
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {badOutPar, strayFault, wordCount, pfAt} = {2'b00, 5'h00, 5'h1F};
        sys_rst = 1'b1;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        t_regs();
        t_inbound();
        t_outbound();
        t_map();
        end_sim();
    end
endmodule // tb
